// ===== fbc_pkg.sv
// Shared constants for the flash bus operation control block.
// Assumes one system clock; all bus pins arrive asynchronously.
package fbc_pkg;

	// ***************************************************
	// Command codes seen on write cycles
	// ***************************************************
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;

	// ***************************************************
	// Status register layout and reset value
	// ***************************************************
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam int SR_READY = 7;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_PROG_ERR = 4;

	// ***************************************************
	// Timing counts in system clock cycles
	// ***************************************************
	localparam logic [15:0] PROG_CYCLES = 16'h0010;

	// ***************************************************
	// Modes and states
	// ***************************************************
	typedef enum logic [0:0] {MODE_ARRAY, MODE_STATUS} fbc_mode_t;
	typedef enum logic [1:0] {PEND_NONE, PEND_PROG, PEND_ERASE} fbc_pend_t;
	typedef enum logic [1:0] {WSM_IDLE, WSM_PROG, WSM_ERASE} fbc_wsm_t;

endpackage : fbc_pkg

// ===== fbc_mem.sv
// Word array behind the flash bus front end.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/10ps
`default_nettype none
module fbc_mem #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 16
) (
	// Clock
	input wire logic clk_sys,
	// Write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// Read port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data_q
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_data_q <= mem[rd_addr];
	end
endmodule : fbc_mem
`default_nettype wire

// ===== fbc_top.sv
// Parallel bus front end of a NOR flash: bus decode, latches, commands.
// Assumes all bus pins are asynchronous to clk_sys; all but sync_mode are filtered here.
//
// How it works
// - Data is driven only with select low, reset high, output enable low and write enable high.
// - The upper address bits are decoded internally into a block number.
// - In asynchronous mode the address latch is open while address valid is low and holds on its rise.
// - In synchronous mode the address latches on the first of address valid rising or a bus clock edge with it low.
// - Address and data of a write are captured on the first rising edge of write enable or select.
// - Output enable high tri-states the data bus and the wait output.
// - Select high is standby with the data bus tri-stated whatever output enable does.
// - A program or erase in progress keeps running when deselected and stops standby.
// - Reset low ignores all controls and tri-states every output driver including wait.
// - After reset the device is in read array, asynchronous unless sync_mode is high, with status holding its default.
// - Reset during a program or erase aborts it, leaving that word or block undefined.
// - Commands arrive as write cycles through a command interface with no address of its own.
// - An internal write state machine runs program and erase on its own once started.
`timescale 1ns/10ps
`default_nettype none
module fbc_top import fbc_pkg::*; #(
	parameter int ADDR_W = 10,
	parameter int BLOCK_W = 3,
	parameter int DATA_W = 16
) (
	// System
	input wire logic clk_sys,
	input wire logic resetn,
	// Bus control pins
	input wire logic bus_clk,
	input wire logic bus_reset_n,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic address_valid_n,
	input wire logic sync_mode,
	// Address and data pins
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic wait_out,
	output logic wait_oe,
	// Power state
	output logic low_power
);
	localparam int PIN_W = 6 + ADDR_W + DATA_W;
	localparam int WORD_W = ADDR_W - BLOCK_W;

	// ***************************************************
	// Pin synchronisers and agreement filter
	// ***************************************************
	logic [PIN_W-1:0] s1_q, s2_q, s3_q, f_q;
	logic clk_f, rst_f, ce_f, oe_f, we_f, adv_f;
	logic [ADDR_W-1:0] addr_f;
	logic [DATA_W-1:0] dq_f;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q <= '0;
		end else begin
			s1_q <= {bus_clk, bus_reset_n, chip_sel_n, out_en_n, write_en_n,
				address_valid_n, addr, dq_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			// A bit moves only once stages two and three agree
			f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
		end
	end
	assign {clk_f, rst_f, ce_f, oe_f, we_f, adv_f, addr_f, dq_f} = f_q;

	function automatic logic [BLOCK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
		block_of = a[ADDR_W-1 -: BLOCK_W];
	endfunction : block_of

	// ***************************************************
	// Address latch
	// ***************************************************
	logic clk_f_q, adv_f_q, sync_lat_q, clk_lat;
	logic [ADDR_W-1:0] lat_addr_q;
	logic sync_rd_ok;

	// Clock only counts in a synchronous read setup
	assign sync_rd_ok = sync_mode && rst_f && !ce_f && we_f;
	assign clk_lat = sync_rd_ok && !adv_f && clk_f && !clk_f_q;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			clk_f_q <= 1'b0;
			adv_f_q <= 1'b1;
		end else begin
			clk_f_q <= clk_f;
			adv_f_q <= adv_f;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn || !rst_f) begin
			lat_addr_q <= '0;
			sync_lat_q <= 1'b0;
		end else if (!sync_mode) begin
			sync_lat_q <= 1'b0;
			if (!adv_f) begin
				lat_addr_q <= addr_f;
			end
		end else begin
			// First of clock edge or address valid rise wins
			if (clk_lat && !sync_lat_q) begin
				lat_addr_q <= addr_f;
				sync_lat_q <= 1'b1;
			end else if (adv_f && !adv_f_q && !sync_lat_q) begin
				lat_addr_q <= addr_f;
			end
			if (adv_f) begin
				sync_lat_q <= 1'b0;
			end
		end
	end

	// ***************************************************
	// Write cycle capture
	// ***************************************************
	logic wr_act, wr_act_q, cmd_stb;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] wr_data_q;

	assign wr_act = rst_f && !ce_f && !we_f && oe_f;
	// Either pin rising ends the cycle; values are those held just before
	assign cmd_stb = wr_act_q && !wr_act && rst_f;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wr_act_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			wr_act_q <= wr_act;
			if (wr_act) begin
				wr_addr_q <= sync_mode ? lat_addr_q : addr_f;
				wr_data_q <= dq_f;
			end
		end
	end

	// ***************************************************
	// Command interface
	// ***************************************************
	fbc_mode_t mode_q;
	fbc_pend_t pend_q;
	fbc_wsm_t wsm_q;
	logic [7:0] status_q;
	logic [7:0] cmd;
	logic start_prog, start_erase, wsm_done;
	logic [ADDR_W-1:0] op_addr_q;
	logic [DATA_W-1:0] op_data_q;

	assign cmd = wr_data_q[7:0];
	assign start_prog = cmd_stb && pend_q == PEND_PROG && wsm_q == WSM_IDLE;
	assign start_erase = cmd_stb && pend_q == PEND_ERASE && cmd == CMD_CONFIRM
		&& wsm_q == WSM_IDLE;

	always_ff @(posedge clk_sys) begin
		if (!resetn || !rst_f) begin
			mode_q <= MODE_ARRAY;
			pend_q <= PEND_NONE;
			status_q <= STATUS_RESET;
		end else begin
			status_q[SR_READY] <= (wsm_q == WSM_IDLE && !start_prog && !start_erase)
				|| wsm_done;
			if (cmd_stb) begin
				pend_q <= PEND_NONE;
				if (pend_q == PEND_PROG) begin
					mode_q <= MODE_STATUS;
				end else if (pend_q == PEND_ERASE) begin
					mode_q <= MODE_STATUS;
					if (cmd != CMD_CONFIRM) begin
						status_q[SR_ERASE_ERR] <= 1'b1;
						status_q[SR_PROG_ERR] <= 1'b1;
					end
				end else begin
					unique case (cmd)
						CMD_READ_ARRAY: mode_q <= MODE_ARRAY;
						CMD_READ_STATUS: mode_q <= MODE_STATUS;
						CMD_CLEAR_STATUS: begin
							status_q[SR_ERASE_ERR] <= 1'b0;
							status_q[SR_PROG_ERR] <= 1'b0;
						end
						CMD_PROGRAM, CMD_PROGRAM_ALT: pend_q <= PEND_PROG;
						CMD_ERASE: pend_q <= PEND_ERASE;
						default: mode_q <= mode_q;
					endcase
				end
			end
		end
	end

	// ***************************************************
	// Write state machine
	// ***************************************************
	logic [15:0] prog_cnt_q;
	logic [WORD_W-1:0] erase_cnt_q;
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;

	assign wsm_done = (wsm_q == WSM_PROG && prog_cnt_q == PROG_CYCLES)
		|| (wsm_q == WSM_ERASE && &erase_cnt_q);

	always_ff @(posedge clk_sys) begin
		if (!resetn || !rst_f) begin
			wsm_q <= WSM_IDLE;
			prog_cnt_q <= '0;
			erase_cnt_q <= '0;
			op_addr_q <= '0;
			op_data_q <= '0;
		end else begin
			unique case (wsm_q)
				WSM_IDLE: begin
					prog_cnt_q <= '0;
					erase_cnt_q <= '0;
					op_addr_q <= wr_addr_q;
					op_data_q <= wr_data_q;
					if (start_prog) begin
						wsm_q <= WSM_PROG;
					end else if (start_erase) begin
						wsm_q <= WSM_ERASE;
					end
				end
				WSM_PROG: begin
					prog_cnt_q <= prog_cnt_q + 16'h0001;
					if (wsm_done) begin
						wsm_q <= WSM_IDLE;
					end
				end
				WSM_ERASE: begin
					erase_cnt_q <= erase_cnt_q + 1'b1;
					if (wsm_done) begin
						wsm_q <= WSM_IDLE;
					end
				end
			endcase
		end
	end

	// Erase walks every word of the decoded block
	assign mem_we = rst_f && ((wsm_q == WSM_PROG && wsm_done)
		|| wsm_q == WSM_ERASE);
	assign mem_waddr = (wsm_q == WSM_ERASE) ?
		{block_of(op_addr_q), erase_cnt_q} : op_addr_q;
	assign mem_wdata = (wsm_q == WSM_ERASE) ? '1 : op_data_q;

	// ***************************************************
	// Array and output drivers
	// ***************************************************
	logic [DATA_W-1:0] rd_data_q, dq_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic wait_q;

	fbc_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(lat_addr_q),
		.rd_data_q(rd_data_q)
	);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dq_q <= '0;
			rd_addr_q <= '0;
			wait_q <= 1'b0;
		end else begin
			rd_addr_q <= lat_addr_q;
			dq_q <= (mode_q == MODE_STATUS) ? {{(DATA_W-8){1'b0}}, status_q}
				: rd_data_q;
			// Wait shows the array word is not yet through the pipeline
			wait_q <= sync_mode && (lat_addr_q != rd_addr_q);
		end
	end

	assign dq_out = dq_q;
	assign wait_out = wait_q;
	// Reset pin and select both gate the driver
	assign dq_oe = resetn && rst_f && !ce_f && !oe_f && we_f;
	// Filtered reset pin low blocks every driver above
	// Wait drives whenever selected with output enable low and reset high, whatever write enable does; tri-states otherwise
	assign wait_oe = resetn && rst_f && !ce_f && !oe_f;
	// Busy array keeps the part out of standby
	assign low_power = !rst_f || (ce_f && wsm_q == WSM_IDLE);

	// ***************************************************
	// Checks
	// ***************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_write_end;
		wr_act ##1 !wr_act && rst_f;
	endsequence
	sequence s_prog_go;
		start_prog && !(!rst_f);
	endsequence

	chk_read_drive: assert property (dq_oe |-> rst_f && !ce_f && !oe_f && we_f)
		else $error("data driven outside a read");
	chk_async_latch: assert property (!sync_mode && !adv_f && rst_f
		&& $past(rst_f) ##1 !sync_mode |-> lat_addr_q == $past(addr_f))
		else $error("async latch not transparent");
	chk_write_capture: assert property (s_write_end |-> cmd_stb)
		else $error("write end not captured");
	chk_oe_tristate: assert property (oe_f |-> !dq_oe && !wait_oe)
		else $error("outputs driven with output enable high");
	chk_standby_hiz: assert property (ce_f |-> !dq_oe && !wait_oe)
		else $error("outputs driven while deselected");
	chk_busy_active: assert property (ce_f && rst_f && wsm_q != WSM_IDLE
		|-> !low_power)
		else $error("standby entered while busy");
	chk_reset_hiz: assert property (!rst_f |-> !dq_oe && !wait_oe)
		else $error("outputs driven during reset");
	chk_reset_default: assert property ($rose(rst_f) |->
		mode_q == MODE_ARRAY && status_q == STATUS_RESET)
		else $error("wrong state after reset release");
	chk_reset_abort: assert property (!rst_f |=> wsm_q == WSM_IDLE)
		else $error("operation survived reset");
	chk_prog_start: assert property (s_prog_go |=> wsm_q == WSM_PROG
		##[1:300] wsm_q == WSM_IDLE)
		else $error("program did not run");
	chk_clk_ignored: assert property (!sync_mode |-> !clk_lat)
		else $error("bus clock used outside sync read");
endmodule : fbc_top
`default_nettype wire

// ===== fbc_host.sv
// Host model that drives the flash bus pins for the bench.
// Assumes every pin change lands 1 ns after a clk_sys rising edge.
`timescale 1ns/10ps
`default_nettype none
module fbc_host (
	// System clock
	input wire logic clk_sys,
	// Pins toward the device
	output logic bus_clk,
	output logic bus_reset_n,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_en_n,
	output logic address_valid_n,
	output logic [9:0] addr,
	output logic [15:0] dq_in,
	// Pins from the device
	input wire logic [15:0] dq_out,
	input wire logic dq_oe
);
	initial begin
		bus_clk = 1'b0;
		bus_reset_n = 1'b1;
		chip_sel_n = 1'b1;
		out_en_n = 1'b1;
		write_en_n = 1'b1;
		address_valid_n = 1'b1;
		addr = 10'h000;
		dq_in = 16'h0000;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : hold
	// Reset pin driven from the rst_n argument along with select and output enable
	task automatic pins(input logic rst_n, input logic sel_n, input logic oe_n);
		bus_reset_n = rst_n;
		chip_sel_n = sel_n;
		out_en_n = oe_n;
		hold(8);
	endtask : pins
	// Released data is inverted so a stale bus never passes as held
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		addr = a;
		dq_in = d;
		address_valid_n = 1'b0;
		chip_sel_n = 1'b0;
		write_en_n = 1'b0;
		hold(8);
		write_en_n = 1'b1;
		hold(6);
		chip_sel_n = 1'b1;
		address_valid_n = 1'b1;
		dq_in = ~d;
		hold(6);
	endtask : wr
	// Bus clock runs only inside a synchronous read frame
	task automatic rd(input logic [9:0] a, input logic lat, input logic sy,
		output logic [16:0] r);
		addr = a;
		address_valid_n = 1'b0;
		chip_sel_n = 1'b0;
		out_en_n = 1'b0;
		hold(6);
		if (sy) begin
			bus_clk = 1'b1;
			hold(10);
			bus_clk = 1'b0;
			addr = ~a;
			hold(10);
		end
		if (lat) begin
			address_valid_n = 1'b1;
			addr = ~a;
		end
		hold(12);
		r = {dq_oe, dq_out};
		out_en_n = 1'b1;
		chip_sel_n = 1'b1;
		address_valid_n = 1'b1;
		hold(6);
	endtask : rd
endmodule : fbc_host
`default_nettype wire

// ===== flash_bus_operation_control_bench.sv
// Self-checking bench: host model plus the flash bus front end.
// Assumes filter delays of a few clk_sys cycles; waits are generous.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_operation_control_bench import fbc_pkg::*;;
	typedef struct packed {logic [9:0] a; logic [15:0] d;} fbc_row_t;
	localparam fbc_row_t ROWS [3] = '{'{10'h000, 16'ha5a5},
		'{10'h17f, 16'h5a0f}, '{10'h3ff, 16'hffff}};
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic sync_mode = 1'b0;
	wire logic bus_clk, bus_reset_n, chip_sel_n, out_en_n, write_en_n;
	wire logic address_valid_n, dq_oe, wait_out, wait_oe, low_power;
	wire logic [9:0] addr;
	wire logic [15:0] dq_in, dq_out;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;
	logic [16:0] r;
	always #4 clk_sys = ~clk_sys;
	fbc_top fbc_top_i (.clk_sys, .resetn, .bus_clk, .bus_reset_n,
		.chip_sel_n, .out_en_n, .write_en_n, .address_valid_n, .sync_mode,
		.addr, .dq_in, .dq_out, .dq_oe, .wait_out, .wait_oe, .low_power);
	fbc_host fbc_host_i (.clk_sys, .bus_clk, .bus_reset_n, .chip_sel_n,
		.out_en_n, .write_en_n, .address_valid_n, .addr, .dq_in, .dq_out,
		.dq_oe);
	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// Status polling is bounded so a stuck state machine cannot hang
	task automatic ready(input logic [9:0] a);
		fbc_host_i.rd(a, 1'b0, 1'b0, r);
		for (int i = 0; i < 30 && r[SR_READY] !== 1'b1; i++)
			fbc_host_i.rd(a, 1'b0, 1'b0, r);
	endtask : ready
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		#1 resetn = 1'b1;
		fbc_host_i.hold(10);
		fbc_host_i.wr(10'h000, {8'h00, CMD_READ_STATUS});
		fbc_host_i.rd(10'h000, 1'b0, 1'b0, r);
		chk(r, {1'b1, 8'h00, STATUS_RESET});
		// Each row: program, then plain, latched and synchronous reads
		foreach (ROWS[i]) begin
			fbc_host_i.wr(ROWS[i].a,
				{8'h00, (i % 2) ? CMD_PROGRAM_ALT : CMD_PROGRAM});
			fbc_host_i.wr(ROWS[i].a, ROWS[i].d);
			ready(ROWS[i].a);
			fbc_host_i.wr(ROWS[i].a, {8'h00, CMD_READ_ARRAY});
			for (int m = 0; m < 3; m++) begin
				sync_mode = (m == 2);
				fbc_host_i.rd(ROWS[i].a, m == 1, m == 2, r);
				chk(r, {1'b1, ROWS[i].d});
				chk({16'h0000, wait_out}, 17'h0_0000);
			end
			sync_mode = 1'b0;
		end
		fbc_host_i.pins(1'b1, 1'b0, 1'b1);
		chk({15'h0000, dq_oe, wait_oe}, 17'h0_0000);
		fbc_host_i.pins(1'b1, 1'b1, 1'b0);
		chk({14'h0000, dq_oe, wait_oe, low_power}, 17'h0_0001);
		fbc_host_i.pins(1'b1, 1'b1, 1'b1);
		// Program keeps the part awake after deselect
		fbc_host_i.wr(10'h005, {8'h00, CMD_PROGRAM});
		fbc_host_i.wr(10'h005, 16'h1234);
		chk({16'h0000, low_power}, 17'h0_0000);
		ready(10'h005);
		fbc_host_i.wr(10'h005, {8'h00, CMD_READ_ARRAY});
		fbc_host_i.rd(10'h005, 1'b0, 1'b0, r);
		chk(r, {1'b1, 16'h1234});
		// Last word of the erased block must survive the cut erase
		fbc_host_i.wr(10'h0ff, {8'h00, CMD_PROGRAM});
		fbc_host_i.wr(10'h0ff, 16'h0f0f);
		ready(10'h0ff);
		// Erase cut short by the reset pin with read controls held active
		fbc_host_i.wr(10'h080, {8'h00, CMD_ERASE});
		fbc_host_i.wr(10'h080, {8'h00, CMD_CONFIRM});
		fbc_host_i.pins(1'b0, 1'b0, 1'b0);
		chk({14'h0000, dq_oe, wait_oe, low_power}, 17'h0_0001);
		fbc_host_i.pins(1'b1, 1'b1, 1'b1);
		fbc_host_i.hold(10);
		fbc_host_i.rd(10'h0ff, 1'b0, 1'b0, r);
		chk(r, {1'b1, 16'h0f0f});
		fbc_host_i.wr(10'h000, {8'h00, CMD_READ_STATUS});
		fbc_host_i.rd(10'h000, 1'b0, 1'b0, r);
		chk(r, {1'b1, 8'h00, STATUS_RESET});
		conclude();
	end
endmodule : flash_bus_operation_control_bench
`default_nettype wire
